// ==== core/muldiv_pkg.sv ====
`default_nettype none

package muldiv_pkg;

	// ------------------------------------------------------------
	// Widths.
	// ------------------------------------------------------------
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned SLICE_W = 16;
	localparam int unsigned CNT_W   = 6;

	// Dividend widths that early-in detection looks for.
	localparam int unsigned FIT_8  = 8;
	localparam int unsigned FIT_16 = 16;
	localparam int unsigned FIT_24 = 24;

	// ------------------------------------------------------------
	// Divide timing.
	// ------------------------------------------------------------
	// Iterations skipped for each dividend width.
	localparam logic [CNT_W-1:0] SKIP_W8  = 6'h17;
	localparam logic [CNT_W-1:0] SKIP_W16 = 6'h0F;
	localparam logic [CNT_W-1:0] SKIP_W24 = 6'h07;
	localparam logic [CNT_W-1:0] SKIP_W32 = 6'h00;

	// Latency in clocks for each dividend width.
	localparam logic [CNT_W-1:0] DIV_LAT_W8  = 6'h0C;
	localparam logic [CNT_W-1:0] DIV_LAT_W16 = 6'h13;
	localparam logic [CNT_W-1:0] DIV_LAT_W24 = 6'h1A;
	localparam logic [CNT_W-1:0] DIV_LAT_W32 = 6'h21;

	// Quotient bits of a full divide, and the highest counter value at
	// which the integer pipeline is no longer held off.
	localparam logic [CNT_W-1:0] DIV_BITS  = 6'h20;
	localparam logic [CNT_W-1:0] CNT_ONE   = 6'h01;

	// ------------------------------------------------------------
	// Enumerations.
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_MULT = 5'h01,
		OP_MADD = 5'h02,
		OP_MSUB = 5'h04,
		OP_MUL  = 5'h08,
		OP_DIV  = 5'h10
	} mdu_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_DIV  = 2'h2
	} div_state_t;

endpackage

`default_nettype wire

// ==== core/muldiv_unit.sv ====
`timescale 1ns/10ps
`default_nettype none

module muldiv_unit (
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire logic                          issue_valid,
	input  wire muldiv_pkg::mdu_op_t           issue_op,
	input  wire logic                          issue_signed,
	input  wire logic [muldiv_pkg::DATA_W-1:0] first_operand,
	input  wire logic [muldiv_pkg::DATA_W-1:0] second_operand,
	output logic                               stall,
	output logic                               div_busy,
	output logic [muldiv_pkg::DATA_W-1:0]      result_high_reg,
	output logic [muldiv_pkg::DATA_W-1:0]      result_low_reg,
	output logic [muldiv_pkg::DATA_W-1:0]      gpr_result,
	output logic                               gpr_valid
);
	import muldiv_pkg::*;

	// ------------------------------------------------------------
	// State.
	// ------------------------------------------------------------
	typedef struct packed {
		div_state_t          state;
		logic [CNT_W-1:0]    div_cnt;
		logic [CNT_W-1:0]    div_iters;
		logic [DATA_W:0]     div_rem;
		logic [DATA_W-1:0]   div_quot;
		logic [DATA_W-1:0]   div_divisor;
		logic                div_neg_q;
		logic                div_neg_r;
		logic                s1_valid;
		mdu_op_t             s1_op;
		logic                s1_wide;
		logic                s1_sgn;
		logic [DATA_W-1:0]   s1_a;
		logic [DATA_W-1:0]   s1_b;
		logic                s2_valid;
		mdu_op_t             s2_op;
		logic                s2_sgn;
		logic [DATA_W-1:0]   s2_a;
		logic [SLICE_W:0]    s2_bhi;
		logic [2*DATA_W-1:0] s2_partial;
		logic [DATA_W-1:0]   gpr_pend;
		logic                gpr_pend_valid;
		logic [DATA_W-1:0]   hi;
		logic [DATA_W-1:0]   lo;
		logic [DATA_W-1:0]   gpr;
		logic                gpr_out;
		logic                stall;
		logic                busy;
	} mdu_state_t;

	mdu_state_t st;
	mdu_state_t next_st;

	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------
	// True when a value is representable in n bits, signed or not.
	// A signed value fits when every bit from n-1 upward copies the sign.
	// An unsigned value fits when every bit from n upward is zero.
	// The same test serves the multiplier and the dividend width.
	function automatic logic fits(input logic [DATA_W-1:0] v,
		input logic sgn, input int unsigned n);
		logic [DATA_W-1:0] up;
		up = sgn ? DATA_W'($signed(v) >>> (n - 1)) : (v >> n);
		return (up == '0) || (sgn && (up == '1));
	endfunction

	// One pass through the 32 by 16 array, with a 17-bit signed slice.
	// The extra slice bit lets a signed narrow operand and the lower
	// half of a wide one share the same array.
	function automatic logic [2*DATA_W-1:0] pass_prod(
		input logic [DATA_W-1:0] a, input logic sgn,
		input logic [SLICE_W:0] b);
		logic signed [DATA_W+SLICE_W+1:0] p;
		p = $signed({sgn & a[DATA_W-1], a}) * $signed(b);
		return (2*DATA_W)'(p);
	endfunction

	// ------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------
	// Computes every register of the unit for the coming edge.
	always_comb begin
		logic                take;
		logic                wide;
		logic                div_done;
		logic                fin;
		mdu_op_t             fop;
		logic [DATA_W-1:0]   div_q;
		logic [DATA_W-1:0]   div_r;
		logic [2*DATA_W-1:0] hilo;
		logic [2*DATA_W-1:0] p1;
		logic [2*DATA_W-1:0] p2;
		logic [2*DATA_W-1:0] fprod;
		logic [DATA_W:0]     shifted;
		logic [DATA_W+1:0]   trial;
		logic                neg_a;
		logic                neg_b;
		logic [DATA_W-1:0]   abs_a;
		logic [DATA_W-1:0]   abs_b;
		logic [CNT_W-1:0]    skip;
		logic [CNT_W-1:0]    lat;
		// Defaults keep the width select free of latches.
		skip = SKIP_W32;
		lat = DIV_LAT_W32;
		next_st = st;
		next_st.gpr_out = 1'b0;
		// Nothing else looks at the stall, so work in flight moves on.
		// Issue gating only.
		take = issue_valid && !st.stall;
		wide = !fits(second_operand, issue_signed, SLICE_W);
		div_done = (st.state == ST_DIV) && (st.div_cnt == '0);
		div_q = st.div_neg_q ? -st.div_quot : st.div_quot;
		div_r = st.div_neg_r ? -st.div_rem[DATA_W-1:0]
			: st.div_rem[DATA_W-1:0];
		// A finishing divide forwards into an accumulate on the same edge.
		hilo = div_done ? {div_r, div_q} : {st.hi, st.lo};
		shifted = {st.div_rem[DATA_W-1:0], st.div_quot[DATA_W-1]};
		trial = {1'b0, shifted} - {2'b00, st.div_divisor};
		neg_a = issue_signed && first_operand[DATA_W-1];
		neg_b = issue_signed && second_operand[DATA_W-1];
		abs_a = neg_a ? -first_operand : first_operand;
		abs_b = neg_b ? -second_operand : second_operand;

		if (fits(first_operand, issue_signed, FIT_8)) begin
			skip = SKIP_W8;
			lat = DIV_LAT_W8;
		end else if (fits(first_operand, issue_signed, FIT_16)) begin
			skip = SKIP_W16;
			lat = DIV_LAT_W16;
		end else if (fits(first_operand, issue_signed, FIT_24)) begin
			skip = SKIP_W24;
			lat = DIV_LAT_W24;
		end else begin
			skip = SKIP_W32;
			lat = DIV_LAT_W32;
		end

		// Divide engine: counts down the latency, steps in the last cycles.
		// The counter idles while it is above the quotient bits left
		// after the skip, so the result lands at the promised latency.
		// Each step is restoring: the trial difference is kept only
		// when it does not borrow.
		unique case (st.state)
			ST_IDLE: begin
				next_st.state = ST_IDLE;
			end
			ST_DIV: begin
				if (div_done) begin
					next_st.hi = div_r;
					next_st.lo = div_q;
					next_st.state = ST_IDLE;
				end else begin
					next_st.div_cnt = st.div_cnt - CNT_ONE;
					if (st.div_cnt <= st.div_iters) begin
						next_st.div_quot = {st.div_quot[DATA_W-2:0],
							!trial[DATA_W+1]};
						next_st.div_rem = trial[DATA_W+1] ? shifted
							: trial[DATA_W:0];
					end
				end
			end
			default: begin
				next_st.state = ST_IDLE;
			end
		endcase

		p1 = pass_prod(st.s1_a, st.s1_sgn, st.s1_wide
			? {1'b0, st.s1_b[SLICE_W-1:0]}
			: {st.s1_sgn & st.s1_b[SLICE_W-1], st.s1_b[SLICE_W-1:0]});
		p2 = st.s2_partial
			+ (pass_prod(st.s2_a, st.s2_sgn, st.s2_bhi) << SLICE_W);
		// Stage two and a narrow stage one never finish on the same edge.
		fin = st.s2_valid || (st.s1_valid && !st.s1_wide);
		fop = st.s2_valid ? st.s2_op : st.s1_op;
		fprod = st.s2_valid ? p2 : p1;

		next_st.gpr_pend_valid = 1'b0;
		if (fin) begin
			unique case (fop)
				OP_MULT: begin
					{next_st.hi, next_st.lo} = fprod;
				end
				OP_MADD: begin
					{next_st.hi, next_st.lo} = hilo + fprod;
				end
				OP_MSUB: begin
					{next_st.hi, next_st.lo} = hilo - fprod;
				end
				OP_MUL: begin
					next_st.gpr_pend = fprod[DATA_W-1:0];
					next_st.gpr_pend_valid = 1'b1;
				end
				default: begin
					next_st.gpr_pend_valid = 1'b0;
				end
			endcase
		end

		// The register form takes one stage more than the accumulator.
		// Extra stage for register write.
		if (st.gpr_pend_valid) begin
			next_st.gpr = st.gpr_pend;
			next_st.gpr_out = 1'b1;
		end

		// Stage one hands a wide multiply to the second pass.
		next_st.s2_valid = st.s1_valid && st.s1_wide;
		next_st.s2_op = st.s1_op;
		next_st.s2_sgn = st.s1_sgn;
		next_st.s2_a = st.s1_a;
		next_st.s2_bhi = {st.s1_sgn & st.s1_b[DATA_W-1],
			st.s1_b[DATA_W-1:SLICE_W]};
		next_st.s2_partial = p1;

		// Issue of a multiply into stage one.
		next_st.s1_valid = take && (issue_op != OP_DIV);
		if (take) begin
			next_st.s1_op = issue_op;
			next_st.s1_wide = wide;
			next_st.s1_sgn = issue_signed;
			next_st.s1_a = first_operand;
			next_st.s1_b = second_operand;
		end

		if (take && (issue_op == OP_DIV)) begin
			next_st.state = ST_DIV;
			next_st.div_quot = abs_a << skip;
			next_st.div_rem = '0;
			next_st.div_divisor = abs_b;
			next_st.div_neg_q = neg_a ^ neg_b;
			next_st.div_neg_r = neg_a;
			next_st.div_iters = DIV_BITS - skip;
			next_st.div_cnt = lat - CNT_ONE;
		end

		// A divide frees the pipeline one cycle before its result.
		// A narrow multiply taken then finishes with the divide and wins.
		// An accumulate taken then adds onto the forwarded result.
		// A second divide taken then restarts the engine.
		// Wide multiply blocks next cycle.
		next_st.stall = (take && (issue_op != OP_DIV) && wide)
			|| ((next_st.state == ST_DIV) && (next_st.div_cnt > CNT_ONE));
		// Busy is kept in a flop so the output needs no decode.
		next_st.busy = (next_st.state == ST_DIV);
	end

	// ------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------
	// All state in one register; reset clears it except the state and op fields.
	// The op fields reset to a legal code so that the stage decoders
	// never meet an all-zero op after reset.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.state <= ST_IDLE;
			st.s1_op <= OP_MULT;
			st.s2_op <= OP_MULT;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register.
	assign stall = st.stall;
	assign div_busy = st.busy;
	assign result_high_reg = st.hi;
	assign result_low_reg = st.lo;
	assign gpr_result = st.gpr;
	assign gpr_valid = st.gpr_out;

endmodule

`default_nettype wire

// ==== tb/muldiv_checker.sv ====
`timescale 1ns/10ps
`default_nettype none

module muldiv_checker (
	input wire logic                clock,
	input wire logic                rst,
	input wire logic                issue_valid,
	input wire muldiv_pkg::mdu_op_t issue_op,
	input wire logic                issue_signed,
	input wire logic [31:0]         first_operand,
	input wire logic [31:0]         second_operand,
	input wire logic                stall,
	input wire logic                div_busy,
	input wire logic [31:0]         result_high_reg,
	input wire logic [31:0]         result_low_reg,
	input wire logic [31:0]         gpr_result,
	input wire logic                gpr_valid
);
	import muldiv_pkg::*;
	logic [63:0] prod;
	logic [31:0] prod_lo;
	logic        take, wide, mul_take;

	// Product, size class and acceptance of the offered op.
	assign prod = {{32{issue_signed & first_operand[31]}}, first_operand}
		* {{32{issue_signed & second_operand[31]}}, second_operand};
	assign prod_lo = prod[31:0];
	assign wide = issue_signed
		? !(second_operand[31:15] inside {17'h0, 17'h1FFFF})
		: second_operand[31:16] != 16'h0;
	assign take = issue_valid && !stall;
	assign mul_take = take && issue_op == OP_MUL;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	wide_stall_a: assert property (
		take && wide && issue_op != OP_DIV |=> stall ##1 !stall)
		else $error("bad wide stall");
	narrow_flow_a: assert property (
		take && !wide && issue_op != OP_DIV |=> !stall)
		else $error("narrow op stalled");
	div_hold_a: assert property (
		take && issue_op == OP_DIV |=> (stall && div_busy) [*8])
		else $error("divide hold short");
	div_end_a: assert property (
		take && issue_op == OP_DIV |-> ##[13:34] $fell(div_busy))
		else $error("divide too long");
	mult_result_a: assert property (
		take && !wide && issue_op == OP_MULT
		|-> ##2 {result_high_reg, result_low_reg} == $past(prod, 2))
		else $error("bad narrow product");
	mul_gpr_a: assert property (
		mul_take && !wide |-> ##3 gpr_valid && gpr_result == $past(prod_lo, 3))
		else $error("bad register product");
	gpr_cause_a: assert property (
		gpr_valid |-> $past(mul_take, 3) || $past(mul_take, 4))
		else $error("stray register write");
	idle_quiet_a: assert property (
		!issue_valid [*3] ##1 (!issue_valid && !div_busy)
		|=> $stable(result_low_reg) && $stable(result_high_reg))
		else $error("result moved when idle");

	cover property (take && issue_op == OP_DIV);
	cover property (take && wide && issue_op == OP_MULT);
	cover property (issue_valid && stall);
endmodule

bind muldiv_unit muldiv_checker chk (.clock, .rst, .issue_valid, .issue_op,
	.issue_signed, .first_operand, .second_operand, .stall, .div_busy,
	.result_high_reg, .result_low_reg, .gpr_result, .gpr_valid);

`default_nettype wire

// ==== tb/int_pipe_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module int_pipe_model (
	input wire logic                clock,
	input wire logic                rst,
	input wire logic                start,
	input wire muldiv_pkg::mdu_op_t req_op,
	input wire logic                req_sgn,
	input wire logic [31:0]         req_a,
	input wire logic [31:0]         req_b,
	input wire logic                stall,
	output logic                    ready,
	output var muldiv_pkg::mdu_op_t issue_op,
	output logic                    issue_valid,
	output logic                    issue_signed,
	output logic [31:0]             first_operand,
	output logic [31:0]             second_operand
);
	import muldiv_pkg::*;

	// The slot frees when empty or when the unit takes the waiting op.
	assign ready = !issue_valid || !stall;

	// An op is held until taken; idle operand lines keep toggling.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			issue_valid <= 1'b0;
			issue_op <= OP_MULT;
			issue_signed <= 1'b0;
			first_operand <= 32'h0;
			second_operand <= 32'h0;
		end else if (ready) begin
			issue_valid <= start;
			issue_op <= req_op;
			issue_signed <= req_sgn;
			first_operand <= start ? req_a : ~first_operand;
			second_operand <= start ? req_b : ~second_operand;
		end
	end
endmodule

`default_nettype wire

// ==== tb/muldiv_unit_bench.sv ====
`timescale 1ns/10ps
`default_nettype none

module muldiv_unit_bench;
	import muldiv_pkg::*;
	logic        clock, rst, start, req_sgn, ready, stall, div_busy;
	logic        issue_valid, issue_signed, gpr_valid;
	mdu_op_t     req_op, issue_op;
	logic [31:0] req_a, req_b, first_operand, second_operand, a, b, gpr;
	logic [31:0] result_high_reg, result_low_reg, gpr_result, seed;
	logic [63:0] acc;
	int          num_errors, tests_run, cyc, last, gap;
	mdu_op_t     ops[5] = '{OP_MULT, OP_MADD, OP_MSUB, OP_MUL, OP_DIV};
	mdu_op_t     op1[3] = '{OP_MADD, OP_MULT, OP_DIV};
	mdu_op_t     op2[3] = '{OP_MSUB, OP_MULT, OP_MADD};
	logic [31:0] y[3] = '{32'h00001234, 32'h00123456, 32'h00000005};
	int          rate[3] = '{1, 2, 11};

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	int_pipe_model pipe (.clock, .rst, .start, .req_op, .req_sgn, .req_a,
		.req_b, .stall, .ready, .issue_op, .issue_valid, .issue_signed,
		.first_operand, .second_operand);
	muldiv_unit uut (.clock, .rst, .issue_valid, .issue_op, .issue_signed,
		.first_operand, .second_operand, .stall, .div_busy,
		.result_high_reg, .result_low_reg, .gpr_result, .gpr_valid);

	// Spacing between ops the unit takes, in clocks.
	always @(posedge clock) begin
		cyc++;
		if (issue_valid && !stall) begin
			gap = cyc - last;
			last = cyc;
		end
	end

	task automatic check(string what, logic [63:0] exp, logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Updates the result model, then offers the op until it is loaded.
	task automatic put(mdu_op_t op, logic s, logic [31:0] x, logic [31:0] w);
		logic [63:0] p;
		p = {{32{s & x[31]}}, x} * {{32{s & w[31]}}, w};
		case (op)
			OP_MULT: acc = p;
			OP_MADD: acc += p;
			OP_MSUB: acc -= p;
			OP_MUL: gpr = p[31:0];
			default: acc = s ? {$signed(x) % $signed(w), $signed(x) / $signed(w)}
				: {x % w, x / w};
		endcase
		start <= 1'b1;
		req_op <= op;
		req_sgn <= s;
		req_a <= x;
		req_b <= w;
		for (int i = 0; i < 40; i++) begin
			@(posedge clock);
			if (ready) break;
		end
	endtask

	// Stops offering and lets all work drain.
	task automatic idle();
		start <= 1'b0;
		for (int i = 0; i < 50; i++) begin
			@(negedge clock);
			if (!issue_valid && !div_busy) break;
		end
		repeat (4) @(negedge clock);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		$display("watchdog expired");
		final_report();
	end

	initial begin
		seed = 32'hF2B5F924;
		rst = 1'b1;
		start = 1'b0;
		req_op = OP_MULT;
		req_sgn = 1'b0;
		req_a = 32'h0;
		req_b = 32'h0;
		acc = 64'h0;
		gpr = 32'h0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		check("reset result", 64'h0, {result_high_reg, result_low_reg});
		$display("test reset done");
		@(posedge clock);
		// Every op code with random widths of both operands.
		for (int i = 0; i < 40; i++) begin
			a = $random(seed) >>> (8 * (i % 4));
			b = $random(seed) >>> (i[1] ? 17 : 0);
			if (i % 5 == 4) b = (b & 32'h00000FFF) | 32'h00000001;
			put(ops[i % 5], i[2], a, b);
			idle();
			check("hi lo", acc, {result_high_reg, result_low_reg});
			check("gpr", 64'(gpr), 64'(gpr_result));
		end
		$display("test random mix done");
		// Back to back narrow, wide, and divide then accumulate.
		for (int j = 0; j < 3; j++) begin
			put(op1[j], 1'b0, 32'h0000007B, y[j]);
			put(op2[j], 1'b0, 32'h0000007B, y[j]);
			idle();
			check("repeat", 64'(rate[j]), 64'(gap));
			check("hi lo", acc, {result_high_reg, result_low_reg});
		end
		$display("test back to back done");
		final_report();
	end
endmodule

`default_nettype wire
